/* File: include/dpr_params.svh */
// Constants for the two-port 512 x 18 RAM and its Avalon-MM config slave.
// Assumes a byte-addressed Avalon-MM master with 32-bit data on clk_in.
`ifndef DPR_PARAMS_SVH
`define DPR_PARAMS_SVH

// Storage geometry
`define DPR_DATA_W        18
`define DPR_ADDR_W        9
`define DPR_DEPTH         512
`define DPR_LANE_W        9
`define DPR_LANES         2
`define DPR_INIT_WORD     18'h0_0000

// Avalon-MM register map, byte addresses
`define DPR_AVS_ADDR_W    4
`define DPR_CFG_OFS       4'h0
`define DPR_STAT_OFS      4'h4

// Config register fields
`define DPR_CFG_W         9
`define DPR_CFG_MODE_A    1:0
`define DPR_CFG_MODE_B    3:2
`define DPR_CFG_OREG_A    4
`define DPR_CFG_OREG_B    5
`define DPR_CFG_LANE_A    6
`define DPR_CFG_LANE_B    7
`define DPR_CFG_SINGLE    8
`define DPR_CFG_RST       9'h000

// Status register fields; the collision flag is write-one-to-clear
`define DPR_STAT_MODE_A   1:0
`define DPR_STAT_MODE_B   3:2
`define DPR_STAT_COLL     4

`define DPR_ZERO_WORD     32'h0000_0000

`endif

/* File: include/dpr_pkg.sv */
// Types for the two-port RAM: write behaviour codes and state records.
// Assumes dpr_params.svh is included by each user.
package dpr_pkg;

  // Write behaviour of a port; code 2'b11 is illegal and acts as hold
  typedef enum logic [1:0] {
    DPR_HOLD  = 2'b00,
    DPR_WTHRU = 2'b01,
    DPR_RBW   = 2'b10
  } dpr_mode_e;

  // Read path of one port
  typedef struct packed {
    logic [17:0] stage_r;  // Synchronous read word
    logic [17:0] out_r;    // Word shown on the read port
  } dpr_port_s;

  // Config slave state
  typedef struct packed {
    logic [8:0]  cfg_r;
    logic        coll_r;
    logic        waitreq_r;
    logic [31:0] rdata_r;
  } dpr_top_s;

endpackage : dpr_pkg

/* File: src/dpr_ram.sv */
// Two-port 512 x 18 synchronous RAM with per-port write behaviour,
// optional output stage, 9-bit byte lanes and an Avalon-MM config slave.
// Assumes both ports and the bus run on clk_in, driven by same-clock logic.
//
// Function
// RQ1: Each read/write port has a write behaviour.
// RQ2: Behaviours: hold, write-through, read-before-write only.
// RQ3: Hold: write leaves read output unchanged.
// RQ4: Write-through: output shows the written data.
// RQ5: Read-before-write: output shows old stored word.
// RQ6: Read-before-write only in single-port configuration.
// RQ7: Unconfigured ports default to hold behaviour.
// RQ8: Eighteen-bit write and read data per port.
// RQ9: Nine-bit address selects one of 512 words.
// RQ10: Optional output stage adds one cycle latency.
// RQ11: Output reset synchronous or asynchronous per port.
// RQ12: Two 9-bit byte lanes; 2'b11 writes all.
// RQ13: Storage holds zero after power-up unless initialised.
// RQ14: Clock enable low: no write, outputs hold.
// RQ15: User avoids same-address writes from both ports.
`timescale 1ns/1ps
`include "dpr_params.svh"

// Read path of one port: synchronous read word plus optional output stage
module dpr_port #(
  parameter bit  RST_ASYNC = 1'b0
) (
  input  wire logic        clk_in,
  input  wire logic        srst_in,
  input  wire logic        port_rst_in,
  input  wire logic        ce_in,
  input  wire logic        we_in,
  input  wire logic [1:0]  mode_in,
  input  wire logic        oreg_in,
  input  wire logic [17:0] stored_in,
  input  wire logic [17:0] merged_in,
  output logic      [17:0] rd_data_out
);
  dpr_pkg::dpr_port_s st_r;
  dpr_pkg::dpr_port_s st_nxt;

  // Next read word by write behaviour
  always_comb begin
    st_nxt = st_r;
    // RQ14 enable low holds
    if (ce_in) begin
      if (!we_in) begin
        st_nxt.stage_r = stored_in;
      end else begin
        // RQ3 RQ4 RQ5 behaviour select
        unique case (mode_in)
          dpr_pkg::DPR_WTHRU: st_nxt.stage_r = merged_in;
          dpr_pkg::DPR_RBW:   st_nxt.stage_r = stored_in;
          default:            st_nxt.stage_r = st_r.stage_r;  // Hold and illegal code
        endcase
      end
      // RQ3 a hold write freezes the shown word as well
      if (!we_in || mode_in == dpr_pkg::DPR_WTHRU || mode_in == dpr_pkg::DPR_RBW) begin
        // RQ10 extra stage when selected
        st_nxt.out_r = oreg_in ? st_r.stage_r : st_nxt.stage_r;
      end
    end
    if (srst_in || port_rst_in) begin
      st_nxt = '0;
    end
  end

  // RQ11 reset style per port
  generate
    if (RST_ASYNC) begin : g_arst
      // Port reset clears at once, without waiting for an edge
      always_ff @(posedge clk_in or posedge port_rst_in) begin
        if (port_rst_in) begin
          st_r <= '0;
        end else begin
          st_r <= st_nxt;
        end
      end
    end else begin : g_srst
      always_ff @(posedge clk_in) begin
        st_r <= st_nxt;
      end
    end
  endgenerate

  assign rd_data_out = st_r.out_r;
endmodule : dpr_port

module dpr_ram #(
  parameter bit          port_a_reset_style = 1'b0,  // 0 sync, 1 async
  parameter bit          port_b_reset_style = 1'b0,
  parameter logic [17:0] INIT_WORD          = `DPR_INIT_WORD
) (
  input  wire logic        clk_in,
  input  wire logic        srst_in,
  // Port A
  input  wire logic        rst_a_in,
  input  wire logic        ce_a_in,
  input  wire logic        we_a_in,
  input  wire logic [1:0]  ben_a_in,
  input  wire logic [8:0]  addr_a_in,
  input  wire logic [17:0] wr_data_a_in,
  output logic      [17:0] rd_data_a_out,
  // Port B
  input  wire logic        rst_b_in,
  input  wire logic        ce_b_in,
  input  wire logic        we_b_in,
  input  wire logic [1:0]  ben_b_in,
  input  wire logic [8:0]  addr_b_in,
  input  wire logic [17:0] wr_data_b_in,
  output logic      [17:0] rd_data_b_out,
  // Avalon-MM config slave
  input  wire logic [3:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest
);
  // RQ9 RQ13 shared 512-word array, powered up to INIT_WORD
  logic [17:0]        mem [0:`DPR_DEPTH-1] = '{default: INIT_WORD};
  dpr_pkg::dpr_top_s  st_r;
  dpr_pkg::dpr_top_s  st_nxt;
  logic               single;
  logic [1:0]         eff_a;
  logic [1:0]         eff_b;
  logic               ce_b;
  logic               wr_a;
  logic               wr_b;
  logic [1:0]         lane_a;
  logic [1:0]         lane_b;
  logic [17:0]        stored_a;
  logic [17:0]        stored_b;
  logic [17:0]        merged_a;
  logic [17:0]        merged_b;

  // All checks below share the one clock; all but a_reset_hold drop out during reset
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (srst_in);

  // Effective write behaviour; illegal or disallowed codes fall to hold
  function automatic logic [1:0] dpr_eff(input logic [1:0] m, input logic sp);
    logic [1:0] r;
    r = dpr_pkg::DPR_HOLD;
    // RQ2 three codes only
    if (m == dpr_pkg::DPR_WTHRU) begin
      r = dpr_pkg::DPR_WTHRU;
    end
    // RQ6 no read-before-write in dual-port
    if (m == dpr_pkg::DPR_RBW && sp) begin
      r = dpr_pkg::DPR_RBW;
    end
    return r;
  endfunction : dpr_eff

  // RQ1 behaviour per port
  assign single = st_r.cfg_r[`DPR_CFG_SINGLE];
  assign eff_a  = dpr_eff(st_r.cfg_r[`DPR_CFG_MODE_A], single);
  assign eff_b  = dpr_eff(st_r.cfg_r[`DPR_CFG_MODE_B], single);
  assign ce_b   = ce_b_in & ~single;  // Port B idles in single-port use

  // RQ14 writes need enable
  assign wr_a   = ce_a_in & we_a_in & ~rst_a_in & ~srst_in;
  assign wr_b   = ce_b & we_b_in & ~rst_b_in & ~srst_in;
  // RQ12 lanes off means whole word
  assign lane_a = st_r.cfg_r[`DPR_CFG_LANE_A] ? ben_a_in : 2'h3;
  assign lane_b = st_r.cfg_r[`DPR_CFG_LANE_B] ? ben_b_in : 2'h3;
  assign stored_a = mem[addr_a_in];
  assign stored_b = mem[addr_b_in];

  // RQ12 merge written lanes over the old word
  genvar gl;
  generate
    for (gl = 0; gl < `DPR_LANES; gl++) begin : g_lane
      assign merged_a[gl*9 +: 9] = lane_a[gl] ? wr_data_a_in[gl*9 +: 9]
                                              : stored_a[gl*9 +: 9];
      assign merged_b[gl*9 +: 9] = lane_b[gl] ? wr_data_b_in[gl*9 +: 9]
                                              : stored_b[gl*9 +: 9];
    end
  endgenerate

  // Array write; on a same-address clash port B lands last (RQ15)
  // Power-up contents sit on the declaration, so only this process writes
  always_ff @(posedge clk_in) begin
    if (wr_a) begin
      mem[addr_a_in] <= merged_a;
    end
    if (wr_b) begin
      mem[addr_b_in] <= merged_b;
    end
  end

  // RQ8 RQ11 read paths
  dpr_port #(.RST_ASYNC(port_a_reset_style)) u_port_a (
    .clk_in      (clk_in),
    .srst_in     (srst_in),
    .port_rst_in (rst_a_in),
    .ce_in       (ce_a_in),
    .we_in       (we_a_in),
    .mode_in     (eff_a),
    .oreg_in     (st_r.cfg_r[`DPR_CFG_OREG_A]),
    .stored_in   (stored_a),
    .merged_in   (merged_a),
    .rd_data_out (rd_data_a_out)
  );
  dpr_port #(.RST_ASYNC(port_b_reset_style)) u_port_b (
    .clk_in      (clk_in),
    .srst_in     (srst_in),
    .port_rst_in (rst_b_in),
    .ce_in       (ce_b),
    .we_in       (we_b_in),
    .mode_in     (eff_b),
    .oreg_in     (st_r.cfg_r[`DPR_CFG_OREG_B]),
    .stored_in   (stored_b),
    .merged_in   (merged_b),
    .rd_data_out (rd_data_b_out)
  );

  // Config slave: one wait cycle, answer when waitrequest is low
  always_comb begin
    logic acc;
    logic hit;
    acc    = 1'b0;
    hit    = 1'b0;
    st_nxt = st_r;
    acc    = (avs_read || avs_write) && st_r.waitreq_r;
    hit    = avs_write && !st_r.waitreq_r;
    st_nxt.waitreq_r = !acc;
    if (acc && avs_read) begin
      st_nxt.rdata_r = `DPR_ZERO_WORD;  // Unmapped reads give zero
      if (avs_address == `DPR_CFG_OFS) begin
        st_nxt.rdata_r[8:0] = st_r.cfg_r;
      end else if (avs_address == `DPR_STAT_OFS) begin
        st_nxt.rdata_r[`DPR_STAT_MODE_A] = eff_a;
        st_nxt.rdata_r[`DPR_STAT_MODE_B] = eff_b;
        st_nxt.rdata_r[`DPR_STAT_COLL]   = st_r.coll_r;
      end
    end
    if (hit && avs_address == `DPR_CFG_OFS) begin
      if (avs_byteenable[0]) begin
        st_nxt.cfg_r[7:0] = avs_writedata[7:0];
      end
      if (avs_byteenable[1]) begin
        st_nxt.cfg_r[8] = avs_writedata[8];
      end
    end
    if (hit && avs_address == `DPR_STAT_OFS && avs_byteenable[0]
        && avs_writedata[`DPR_STAT_COLL]) begin
      st_nxt.coll_r = 1'b0;
    end
    // Clash seen after the clear, so a new one is never lost
    if (wr_a && wr_b && addr_a_in == addr_b_in) begin
      st_nxt.coll_r = 1'b1;
    end
    // RQ7 hold after reset
    if (srst_in) begin
      st_nxt = '0;
      st_nxt.cfg_r     = `DPR_CFG_RST;
      st_nxt.waitreq_r = 1'b1;
    end
  end

  always_ff @(posedge clk_in) begin
    st_r <= st_nxt;
  end

  assign avs_readdata    = st_r.rdata_r;
  assign avs_waitrequest = st_r.waitreq_r;

  a_hold_output: assert property (  // RQ3
    wr_a && eff_a == dpr_pkg::DPR_HOLD && !st_r.cfg_r[`DPR_CFG_OREG_A] && !rst_a_in
    |=> $stable(rd_data_a_out)
  ) else $error("hold write changed port A output");

  a_write_through: assert property (  // RQ4
    wr_a && eff_a == dpr_pkg::DPR_WTHRU && !st_r.cfg_r[`DPR_CFG_OREG_A]
    |=> rd_data_a_out == $past(merged_a)
  ) else $error("write-through output wrong on port A");

  a_read_before: assert property (  // RQ5
    wr_a && eff_a == dpr_pkg::DPR_RBW && !st_r.cfg_r[`DPR_CFG_OREG_A]
    |=> rd_data_a_out == $past(stored_a) && mem[$past(addr_a_in)] == $past(merged_a)
  ) else $error("read-before-write output wrong on port A");

  a_rbw_dual_off: assert property (  // RQ6
    !single |-> eff_a != dpr_pkg::DPR_RBW && eff_b != dpr_pkg::DPR_RBW
  ) else $error("read-before-write active in dual-port use");

  a_mode_legal: assert property (  // RQ2
    eff_a != 2'h3 && eff_b != 2'h3
  ) else $error("illegal write behaviour code in use");

  a_reset_hold: assert property (  // RQ7
    @(posedge clk_in) disable iff (1'b0)
    srst_in |=> eff_a == dpr_pkg::DPR_HOLD && eff_b == dpr_pkg::DPR_HOLD
      && rd_data_a_out == 18'h0_0000
  ) else $error("reset did not restore hold and clear output");

  a_oreg_latency: assert property (  // RQ10
    ce_a_in && !we_a_in && !rst_a_in && st_r.cfg_r[`DPR_CFG_OREG_A]
    ##1 ce_a_in && !rst_a_in && st_r.cfg_r[`DPR_CFG_OREG_A]
    |=> rd_data_a_out == $past(stored_a, 2)
  ) else $error("output stage latency wrong on port A");

  a_ce_low_hold: assert property (  // RQ14
    !ce_a_in && !rst_a_in |=> $stable(rd_data_a_out)
      && mem[$past(addr_a_in)] == $past(stored_a) || $past(wr_b)
  ) else $error("port A changed with enable low");

  a_lane_write: assert property (  // RQ12
    wr_a && lane_a == 2'h1 && !wr_b
    |=> mem[$past(addr_a_in)] == {$past(stored_a[17:9]), $past(wr_data_a_in[8:0])}
  ) else $error("byte lane write touched wrong lane");

  a_coll_sticky: assert property (  // RQ15
    wr_a && wr_b && addr_a_in == addr_b_in |=> st_r.coll_r
  ) else $error("collision flag lost");

  // Port B mirrors of the hold and write-through checks
  a_hold_output_b: assert property (  // RQ3
    wr_b && eff_b == dpr_pkg::DPR_HOLD && !st_r.cfg_r[`DPR_CFG_OREG_B] && !rst_b_in
    |=> $stable(rd_data_b_out)
  ) else $error("hold write changed port B output");

  a_write_through_b: assert property (  // RQ4
    wr_b && eff_b == dpr_pkg::DPR_WTHRU && !st_r.cfg_r[`DPR_CFG_OREG_B]
    |=> rd_data_b_out == $past(merged_b)
  ) else $error("write-through output wrong on port B");

  // Port B is parked while the block runs as a single-port RAM
  a_single_b_idle: assert property (  // RQ6
    single && !rst_b_in |=> $stable(rd_data_b_out)
  ) else $error("port B output moved in single-port use");

  a_ce_low_hold_b: assert property (  // RQ14
    !ce_b && !rst_b_in |=> $stable(rd_data_b_out)
  ) else $error("port B changed with enable low");

  a_port_rst_clear: assert property (  // RQ11
    rst_a_in |=> rd_data_a_out == 18'h0_0000
  ) else $error("port reset did not clear port A output");
endmodule : dpr_ram

/* File: sim/dpr_fab.sv */
// Fabric model that drives RAM port B, one access per call.
// Assumes the bench calls acc from its main process on clk_in.
`timescale 1ns/1ps
module dpr_fab (
  input  wire logic   clk_in,
  output logic        ce_out,
  output logic        we_out,
  output logic [8:0]  addr_out,
  output logic [17:0] wd_out
);
  // Idle at time zero
  initial begin
    ce_out = 1'b0;
    we_out = 1'b0;
    addr_out = 9'h000;
    wd_out = 18'h0_0000;
  end
  task automatic acc(input logic w, input logic [8:0] a, input logic [17:0] d);
    @(posedge clk_in);
    ce_out <= 1'b1;
    we_out <= w;
    addr_out <= a;
    wd_out <= d;
    @(posedge clk_in);
    ce_out <= 1'b0;
    we_out <= 1'b0;
    // Released lines flip so stale values are never seen
    addr_out <= ~a;
    wd_out <= ~d;
    #1;
  endtask : acc
endmodule : dpr_fab

/* File: sim/tb.sv */
// Self-checking bench: Avalon config accesses plus port A/B accesses.
// Assumes one 40 MHz clock and one wait state on the config slave.
`timescale 1ns/1ps
module tb;
  logic        clk_in = 1'b0;
  logic        srst_in = 1'b1;
  logic        rst_a, ce_a, we_a;
  logic [1:0]  ben_a;
  logic [8:0]  addr_a;
  logic [17:0] wd_a, rd_a, rd_b, wd_b;
  logic        ce_b, we_b;
  logic [8:0]  addr_b;
  logic [3:0]  avs_address;
  logic        avs_read, avs_write, avs_waitrequest;
  logic [31:0] avs_writedata, avs_readdata, q;
  int          error_cnt = 0;
  int          n_compared = 0;

  // 25 ns clock
  always #12.5 clk_in = ~clk_in;

  dpr_ram dpr_ram_inst (.clk_in(clk_in), .srst_in(srst_in),
    .rst_a_in(rst_a), .ce_a_in(ce_a), .we_a_in(we_a), .ben_a_in(ben_a),
    .addr_a_in(addr_a), .wr_data_a_in(wd_a), .rd_data_a_out(rd_a),
    .rst_b_in(1'b0), .ce_b_in(ce_b), .we_b_in(we_b), .ben_b_in(2'b11),
    .addr_b_in(addr_b), .wr_data_b_in(wd_b), .rd_data_b_out(rd_b),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(4'hF),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest));

  dpr_fab dpr_fab_inst (.clk_in(clk_in), .ce_out(ce_b), .we_out(we_b),
    .addr_out(addr_b), .wd_out(wd_b));

  task automatic close_out;
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : close_out

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_compared++;
    if (g !== e) begin
      $display("mismatch t=%0t got=%h exp=%h", $time, g, e);
      error_cnt++;
    end
  endtask : chk

  // Avalon master: hold until waitrequest is sampled low
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    @(posedge clk_in);
    avs_address <= a;
    avs_write <= w;
    avs_read <= !w;
    avs_writedata <= d;
    @(posedge clk_in);
    while (avs_waitrequest !== 1'b0) @(posedge clk_in);
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask : bus

  // One enabled port A access; returns once the unstaged answer is out
  task automatic pa(input logic w, input logic [8:0] a, input logic [17:0] d);
    @(posedge clk_in);
    ce_a <= 1'b1;
    we_a <= w;
    addr_a <= a;
    wd_a <= d;
    @(posedge clk_in);
    ce_a <= 1'b0;
    we_a <= 1'b0;
    #1;
  endtask : pa

  // Hang guard, far beyond the eighty or so cycles needed
  initial begin
    #50us;
    error_cnt++;
    close_out();
  end

  // Main sequence
  initial begin
    {rst_a, ce_a, we_a, addr_a, wd_a} = '0;
    ben_a = 2'b11;
    {avs_address, avs_read, avs_write, avs_writedata} = '0;
    repeat (2) @(posedge clk_in);
    srst_in <= 1'b0;
    bus(0, 4'h0, 0);
    chk(q, 32'h0000_0000);
    bus(0, 4'h4, 0);
    chk(q, 32'h0000_0000);
    // Unmapped offset: write ignored, read gives zero
    bus(1, 4'hC, 32'h0000_01FF);
    bus(0, 4'hC, 0);
    chk(q, 32'h0000_0000);
    bus(0, 4'h0, 0);
    chk(q, 32'h0000_0000);
    pa(0, 9'h1FF, 0);
    chk(rd_a, 18'h0_0000);
    pa(1, 9'h1FF, 18'h2_5A5A);
    chk(rd_a, 18'h0_0000);
    pa(0, 9'h1FF, 0);
    chk(rd_a, 18'h2_5A5A);
    bus(1, 4'h0, 32'h0000_0001);
    pa(1, 9'h005, 18'h1_2345);
    chk(rd_a, 18'h1_2345);
    bus(1, 4'h0, 32'h0000_0002);
    bus(0, 4'h4, 0);
    chk(q, 32'h0000_0000);
    pa(1, 9'h006, 18'h0_0777);
    chk(rd_a, 18'h1_2345);
    bus(1, 4'h0, 32'h0000_0102);
    bus(0, 4'h4, 0);
    chk(q, 32'h0000_0002);
    pa(1, 9'h006, 18'h3_FFFF);
    chk(rd_a, 18'h0_0777);
    // Output stage: two enabled reads back to back, data one cycle late
    bus(1, 4'h0, 32'h0000_0010);
    @(posedge clk_in);
    ce_a <= 1'b1;
    addr_a <= 9'h1FF;
    @(posedge clk_in);
    addr_a <= 9'h005;
    #1 chk(rd_a, 18'h0_0777);
    @(posedge clk_in);
    ce_a <= 1'b0;
    #1 chk(rd_a, 18'h2_5A5A);
    // Lane write in hold: only the low lane changes, shown word stays
    bus(1, 4'h0, 32'h0000_0040);
    @(posedge clk_in);
    ben_a <= 2'b01;
    pa(1, 9'h1FF, 18'h0_0000);
    chk(rd_a, 18'h2_5A5A);
    @(posedge clk_in);
    ben_a <= 2'b11;
    pa(0, 9'h1FF, 0);
    chk(rd_a, 18'h2_5A00);
    // Write attempt with enable low must not land
    @(posedge clk_in);
    we_a <= 1'b1;
    addr_a <= 9'h1FF;
    wd_a <= 18'h3_FFFF;
    @(posedge clk_in);
    we_a <= 1'b0;
    #1 chk(rd_a, 18'h2_5A00);
    pa(0, 9'h1FF, 0);
    chk(rd_a, 18'h2_5A00);
    dpr_fab_inst.acc(1, 9'h0AA, 18'h1_0F0F);
    pa(0, 9'h0AA, 0);
    chk(rd_a, 18'h1_0F0F);
    dpr_fab_inst.acc(0, 9'h006, 0);
    chk(rd_b, 18'h3_FFFF);
    bus(1, 4'h0, 32'h0000_0004);
    dpr_fab_inst.acc(1, 9'h0AB, 18'h0_1111);
    chk(rd_b, 18'h0_1111);
    @(posedge clk_in);
    rst_a <= 1'b1;
    @(posedge clk_in);
    rst_a <= 1'b0;
    #1 chk(rd_a, 18'h0_0000);
    // Reset in mid-run restores the default config and clears port B
    @(posedge clk_in);
    srst_in <= 1'b1;
    @(posedge clk_in);
    srst_in <= 1'b0;
    bus(0, 4'h0, 0);
    chk(q, 32'h0000_0000);
    chk(rd_b, 18'h0_0000);
    close_out();
  end
endmodule : tb
